//--- design/rab_alu_top.sv
// Avalon-MM wrapped rotate and borrow-subtract ALU.
// Operation
// - Left rotate through carry into accumulator; memory bit 7 becomes carry.
// - Plain right rotate of memory, bit 0 into bit 7, flags untouched.
// - Right rotate into accumulator, memory and flags left unchanged.
// - Right rotate memory through carry; only carry changes.
// - Right rotate through carry into accumulator; memory unchanged.
// - Accumulator minus memory minus inverted carry, stored in accumulator.
// - After subtract, carry is 0 on negative result, else 1.
`timescale 1ns/1ps
`default_nettype none
module rab_alu_top #(
   parameter int DATA_W = 8
) (
   // Clock, reset, enable
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_NRST,
   input  wire logic        I_CE,
   // Avalon-MM slave
   input  wire logic [7:0]  I_AVS_ADDRESS,
   input  wire logic        I_AVS_READ,
   input  wire logic        I_AVS_WRITE,
   input  wire logic [31:0] I_AVS_WRITEDATA,
   input  wire logic [3:0]  I_AVS_BYTEENABLE,
   output logic      [31:0] O_AVS_READDATA,
   output logic             O_AVS_WAITREQUEST,
   // Datapath state
   output logic      [7:0]  O_ACC,
   output logic      [7:0]  O_MEM,
   output logic      [3:0]  O_FLAGS,
   output logic             O_DONE
);

   // =========================================================
   // Declarations
   // =========================================================
   rab_pkg::rab_bus_state_t state_reg;
   rab_pkg::rab_bus_state_t state_next;

   logic [DATA_W-1:0] acc_reg;
   logic [DATA_W-1:0] mem_reg;
   logic [DATA_W-1:0] result_reg;
   logic [3:0]        flags_reg;
   logic [2:0]        op_reg;
   logic              exec_reg;
   logic              done_reg;
   logic              dst_acc_reg;
   logic              dst_mem_reg;
   logic [31:0]       rdata_reg;

   logic              req;
   logic              accept;
   logic              commit;
   logic              wr_low;
   logic [5:0]        word_idx;
   logic [DATA_W-1:0] core_result;
   logic              core_to_acc;
   logic              core_to_mem;
   logic [3:0]        core_flags;
   logic [31:0]       rd_mux;

   // =========================================================
   // Bus handshake
   // =========================================================
   assign req = I_AVS_READ | I_AVS_WRITE;

   // A pending execution holds off new accesses, so a read never
   // sees a value that is one cycle from being overwritten.
   assign accept = req & ~exec_reg & (state_reg == rab_pkg::ST_IDLE);

   // The access completes at the edge that sees waitrequest low;
   // a low enable keeps waitrequest up so no write is dropped
   assign commit = req & I_CE & (state_reg == rab_pkg::ST_ANSWER);

   assign O_AVS_WAITREQUEST = req
                            & (~I_CE | (state_reg != rab_pkg::ST_ANSWER));

   // Only the low byte lane carries data; upper lanes are ignored
   assign wr_low = I_AVS_WRITE & commit & I_AVS_BYTEENABLE[0];

   assign word_idx = I_AVS_ADDRESS[7:2];

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         rab_pkg::ST_IDLE: begin
            if (accept) begin
               state_next = rab_pkg::ST_ANSWER;
            end
         end
         rab_pkg::ST_ANSWER: begin
            state_next = rab_pkg::ST_IDLE;
         end
         default: begin
            state_next = rab_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         state_reg <= rab_pkg::ST_IDLE;
      end else if (I_CE) begin
         state_reg <= state_next;
      end
   end

   // =========================================================
   // Read path
   // =========================================================
   always_comb begin
      rd_mux = rab_pkg::RD_ZERO;
      case (word_idx)
         rab_pkg::OFS_CTRL[7:2]: begin
            rd_mux[rab_pkg::FLD_OP_MSB:rab_pkg::FLD_OP_LSB] = op_reg;
            rd_mux[rab_pkg::FLD_DST_ACC] = dst_acc_reg;
            rd_mux[rab_pkg::FLD_DST_MEM] = dst_mem_reg;
         end
         rab_pkg::OFS_MEM[7:2]: begin
            rd_mux[DATA_W-1:0] = mem_reg;
         end
         rab_pkg::OFS_ACC[7:2]: begin
            rd_mux[DATA_W-1:0] = acc_reg;
         end
         rab_pkg::OFS_FLAGS[7:2]: begin
            rd_mux[3:0] = flags_reg;
         end
         rab_pkg::OFS_RESULT[7:2]: begin
            rd_mux[DATA_W-1:0] = result_reg;
         end
         default: begin
            rd_mux = rab_pkg::RD_ZERO;
         end
      endcase
   end

   // Captured when the access is accepted, stable at the answer edge
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rdata_reg <= rab_pkg::RD_ZERO;
      end else if (I_CE) begin
         if (accept & I_AVS_READ) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   assign O_AVS_READDATA = rdata_reg;

   // =========================================================
   // Operation launch
   // =========================================================
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         op_reg   <= 3'h0;
         exec_reg <= 1'b0;
      end else if (I_CE) begin
         if (wr_low && word_idx == rab_pkg::OFS_CTRL[7:2]) begin
            op_reg   <= I_AVS_WRITEDATA[rab_pkg::FLD_OP_MSB:
                                        rab_pkg::FLD_OP_LSB];
            exec_reg <= 1'b1;
         end else begin
            exec_reg <= 1'b0;
         end
      end
   end

   // =========================================================
   // Datapath
   // =========================================================
   rab_alu_core #(
      .W        (DATA_W)
   ) u_core (
      .i_op     (op_reg),
      .i_mem    (mem_reg),
      .i_acc    (acc_reg),
      .i_flags  (flags_reg),
      .o_result (core_result),
      .o_to_acc (core_to_acc),
      .o_to_mem (core_to_mem),
      .o_flags  (core_flags)
   );

   // Accumulator: software write or accumulator-destination result
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         acc_reg <= rab_pkg::RST_BYTE;
      end else if (I_CE) begin
         if (exec_reg && core_to_acc) begin
            acc_reg <= core_result;
         end else if (wr_low && word_idx == rab_pkg::OFS_ACC[7:2]) begin
            acc_reg <= I_AVS_WRITEDATA[DATA_W-1:0];
         end
      end
   end

   // Memory operand: software write or memory-destination result
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         mem_reg <= rab_pkg::RST_BYTE;
      end else if (I_CE) begin
         if (exec_reg && core_to_mem) begin
            mem_reg <= core_result;
         end else if (wr_low && word_idx == rab_pkg::OFS_MEM[7:2]) begin
            mem_reg <= I_AVS_WRITEDATA[DATA_W-1:0];
         end
      end
   end

   // Hardware update wins over a software write in the same cycle
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         flags_reg <= rab_pkg::RST_FLAGS;
      end else if (I_CE) begin
         if (exec_reg) begin
            flags_reg <= core_flags;
         end else if (wr_low && word_idx == rab_pkg::OFS_FLAGS[7:2]) begin
            flags_reg <= I_AVS_WRITEDATA[3:0];
         end
      end
   end

   // Result, destination record and completion pulse
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         result_reg  <= rab_pkg::RST_BYTE;
         dst_acc_reg <= 1'b0;
         dst_mem_reg <= 1'b0;
         done_reg    <= 1'b0;
      end else if (I_CE) begin
         done_reg <= exec_reg;
         if (exec_reg) begin
            result_reg  <= core_result;
            dst_acc_reg <= core_to_acc;
            dst_mem_reg <= core_to_mem;
         end
      end
   end

   // =========================================================
   // Outputs
   // =========================================================
   assign O_ACC   = acc_reg;
   assign O_MEM   = mem_reg;
   assign O_FLAGS = flags_reg;
   assign O_DONE  = done_reg;

endmodule
`default_nettype wire

//--- shared/rab_pkg.sv
// Shared constants and types for the rotate and borrow-subtract ALU.
`default_nettype none
package rab_pkg;

   // ==========================================================
   // Data widths
   // ==========================================================
   localparam int DATA_W   = 8;
   localparam int BUS_W    = 32;
   localparam int ADDR_W   = 8;
   localparam int BE_W     = 4;
   localparam int FLAG_W   = 4;
   localparam int OP_W     = 3;

   // ==========================================================
   // Register byte offsets
   // ==========================================================
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_MEM    = 8'h04;
   localparam logic [7:0] OFS_ACC    = 8'h08;
   localparam logic [7:0] OFS_FLAGS  = 8'h0C;
   localparam logic [7:0] OFS_RESULT = 8'h10;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int FLD_OP_LSB  = 0;
   localparam int FLD_OP_MSB  = 2;
   localparam int FLD_DST_ACC = 3;
   localparam int FLD_DST_MEM = 4;
   localparam int FLG_C       = 0;
   localparam int FLG_AC      = 1;
   localparam int FLG_Z       = 2;
   localparam int FLG_OV      = 3;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [3:0]  RST_FLAGS = 4'h0;
   localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

   // ==========================================================
   // Operation codes
   // ==========================================================
   typedef enum logic [2:0] {
      OP_NONE                  = 3'h0,
      OP_ROT_LEFT_CARRY_TO_ACC = 3'h1,
      OP_ROT_RIGHT_MEM         = 3'h2,
      OP_ROT_RIGHT_TO_ACC      = 3'h3,
      OP_ROT_RIGHT_CARRY_MEM   = 3'h4,
      OP_ROT_RIGHT_CARRY_ACC   = 3'h5,
      OP_SUB_BORROW_TO_ACC     = 3'h6
   } rab_op_t;

   // ==========================================================
   // Bus slave states, Gray coded
   // ==========================================================
   typedef enum logic [1:0] {
      ST_IDLE   = 2'h0,
      ST_ANSWER = 2'h1
   } rab_bus_state_t;

endpackage
`default_nettype wire

//--- design/rab_alu_core.sv
// Combinational datapath for the rotate and borrow-subtract operations.
`timescale 1ns/1ps
`default_nettype none
module rab_alu_core #(
   parameter int W = 8
) (
   // Operation and operands
   input  wire logic [2:0]   i_op,
   input  wire logic [W-1:0] i_mem,
   input  wire logic [W-1:0] i_acc,
   input  wire logic [3:0]   i_flags,
   // Results
   output logic      [W-1:0] o_result,
   output logic              o_to_acc,
   output logic              o_to_mem,
   output logic      [3:0]   o_flags
);

   // =========================================================
   // Subtract with borrow
   // =========================================================
   logic         carry_in;
   logic         borrow_in;
   logic [W:0]   diff;
   logic [4:0]   nib_diff;
   logic [W-1:0] diff_byte;

   assign carry_in  = i_flags[rab_pkg::FLG_C];
   assign borrow_in = ~carry_in;
   // Extra top bit catches the borrow out of the whole byte
   assign diff = {1'b0, i_acc} - {1'b0, i_mem} - {{W{1'b0}}, borrow_in};
   assign nib_diff = {1'b0, i_acc[3:0]} - {1'b0, i_mem[3:0]}
                   - {4'h0, borrow_in};
   assign diff_byte = diff[W-1:0];

   // =========================================================
   // Operation select
   // =========================================================
   always_comb begin
      o_result = i_mem;
      o_to_acc = 1'b0;
      o_to_mem = 1'b0;
      o_flags  = i_flags;
      case (rab_pkg::rab_op_t'(i_op))
         rab_pkg::OP_ROT_LEFT_CARRY_TO_ACC: begin
            o_result = {i_mem[W-2:0], carry_in};
            o_to_acc = 1'b1;
            o_flags[rab_pkg::FLG_C] = i_mem[W-1];
         end
         rab_pkg::OP_ROT_RIGHT_MEM: begin
            o_result = {i_mem[0], i_mem[W-1:1]};
            o_to_mem = 1'b1;
         end
         rab_pkg::OP_ROT_RIGHT_TO_ACC: begin
            o_result = {i_mem[0], i_mem[W-1:1]};
            o_to_acc = 1'b1;
         end
         rab_pkg::OP_ROT_RIGHT_CARRY_MEM: begin
            o_result = {carry_in, i_mem[W-1:1]};
            o_to_mem = 1'b1;
            o_flags[rab_pkg::FLG_C] = i_mem[0];
         end
         rab_pkg::OP_ROT_RIGHT_CARRY_ACC: begin
            o_result = {carry_in, i_mem[W-1:1]};
            o_to_acc = 1'b1;
            o_flags[rab_pkg::FLG_C] = i_mem[0];
         end
         rab_pkg::OP_SUB_BORROW_TO_ACC: begin
            o_result = diff_byte;
            o_to_acc = 1'b1;
            // Carry reads as an active-low borrow
            o_flags[rab_pkg::FLG_C]  = ~diff[W];
            o_flags[rab_pkg::FLG_AC] = ~nib_diff[4];
            o_flags[rab_pkg::FLG_Z]  = (diff_byte == '0);
            o_flags[rab_pkg::FLG_OV] = (i_acc[W-1] ^ i_mem[W-1])
                                     & (i_acc[W-1] ^ diff_byte[W-1]);
         end
         default: begin
            o_result = i_mem;
         end
      endcase
   end

endmodule
`default_nettype wire

//--- sim/rab_alu_monitor.sv
// Port-level assertions for the rotate and borrow-subtract ALU.
`timescale 1ns/1ps
`default_nettype none
module rab_alu_monitor (
   // Clock and reset
   input wire logic        I_CORE_CLK,
   input wire logic        I_NRST,
   input wire logic        I_CE,
   // Register bus
   input wire logic [7:0]  I_AVS_ADDRESS,
   input wire logic        I_AVS_READ,
   input wire logic        I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   input wire logic [3:0]  I_AVS_BYTEENABLE,
   input wire logic [31:0] O_AVS_READDATA,
   input wire logic        O_AVS_WAITREQUEST,
   // Datapath state
   input wire logic [7:0]  O_ACC,
   input wire logic [7:0]  O_MEM,
   input wire logic [3:0]  O_FLAGS,
   input wire logic        O_DONE
);
   // ==========================================================
   // Launch detection
   // ==========================================================
   logic       go;
   logic [2:0] op;
   assign go = I_AVS_WRITE && !O_AVS_WAITREQUEST && I_CE
               && I_AVS_BYTEENABLE[0] && I_AVS_ADDRESS[7:2] == 6'h00;
   assign op = I_AVS_WRITEDATA[2:0];

   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_NRST);

   // ==========================================================
   // Bus and completion
   // ==========================================================
   chk_wait_bound: assert property (
      (I_AVS_READ || I_AVS_WRITE) && I_CE |-> ##[0:2] !O_AVS_WAITREQUEST)
      else $error("waitrequest held too long");
   chk_wait_idle: assert property (
      !I_AVS_READ && !I_AVS_WRITE |-> !O_AVS_WAITREQUEST)
      else $error("waitrequest without a request");
   chk_done_once: assert property (O_DONE |=> !O_DONE)
      else $error("done longer than one cycle");
   chk_done_cause: assert property (go |-> ##[1:2] O_DONE)
      else $error("done missing after launch");
   chk_ce_freeze: assert property (
      !I_CE |=> $stable(O_ACC) && $stable(O_MEM) && $stable(O_FLAGS)
      && $stable(O_DONE))
      else $error("state moved while enable low");

   // ==========================================================
   // Operations: results seen two edges after the launch
   // ==========================================================
   chk_rot_left: assert property (
      go && op == 3'h1 |=> ##1 O_ACC == {$past(O_MEM[6:0]), $past(O_FLAGS[0])}
      && O_FLAGS[0] == $past(O_MEM[7]) && O_MEM == $past(O_MEM))
      else $error("left rotate to accumulator wrong");
   chk_rot_mem: assert property (
      go && op == 3'h2 |=> ##1 O_MEM == {$past(O_MEM[0]), $past(O_MEM[7:1])}
      && O_FLAGS == $past(O_FLAGS))
      else $error("right rotate of memory wrong");
   chk_rot_acc: assert property (
      go && op == 3'h3 |=> ##1 O_ACC == {$past(O_MEM[0]), $past(O_MEM[7:1])}
      && O_FLAGS == $past(O_FLAGS) && O_MEM == $past(O_MEM))
      else $error("right rotate to accumulator wrong");
   chk_rot_cmem: assert property (
      go && op == 3'h4 |=> ##1 O_MEM == {$past(O_FLAGS[0]), $past(O_MEM[7:1])}
      && O_FLAGS == {$past(O_FLAGS[3:1]), $past(O_MEM[0])})
      else $error("right rotate through carry wrong");
   chk_rot_cacc: assert property (
      go && op == 3'h5 |=> ##1 O_ACC == {$past(O_FLAGS[0]), $past(O_MEM[7:1])}
      && O_FLAGS == {$past(O_FLAGS[3:1]), $past(O_MEM[0])}
      && O_MEM == $past(O_MEM))
      else $error("right rotate through carry to accumulator wrong");
   chk_sub_value: assert property (
      go && op == 3'h6 |=> ##1 O_ACC == $past(O_ACC) - $past(O_MEM)
      - {7'h00, !$past(O_FLAGS[0])} && O_FLAGS[2] == (O_ACC == 8'h00))
      else $error("subtract result or zero flag wrong");
   chk_sub_carry: assert property (
      go && op == 3'h6 |=> ##1 O_FLAGS[0] == ({1'b0, $past(O_ACC)}
      >= {1'b0, $past(O_MEM)} + {8'h00, !$past(O_FLAGS[0])}))
      else $error("subtract carry wrong");
endmodule

bind rab_alu_top rab_alu_monitor rab_alu_monitor_inst (
   .I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_CE(I_CE),
   .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ),
   .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
   .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
   .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_ACC(O_ACC), .O_MEM(O_MEM),
   .O_FLAGS(O_FLAGS), .O_DONE(O_DONE)
);
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the rotate and borrow-subtract ALU.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk;
   logic        nrst;
   logic        ce;
   logic [7:0]  addr;
   logic        rd_req;
   logic        wr_req;
   logic [31:0] wdata;
   logic [3:0]  be;
   logic [31:0] rdata;
   logic        waitreq;
   logic [7:0]  em;
   logic [7:0]  ea;
   logic [7:0]  er;
   logic [3:0]  ef;
   logic [8:0]  d;
   logic [4:0]  nb;
   logic [31:0] exp_q[$];
   int          mismatches = 0;
   int          cmp_count = 0;
   int          cyc = 0;

   rab_alu_top rab_alu_top_inst (
      .I_CORE_CLK(clk), .I_NRST(nrst), .I_CE(ce), .I_AVS_ADDRESS(addr),
      .I_AVS_READ(rd_req), .I_AVS_WRITE(wr_req), .I_AVS_WRITEDATA(wdata),
      .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
      .O_AVS_WAITREQUEST(waitreq), .O_ACC(), .O_MEM(), .O_FLAGS(),
      .O_DONE());

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ==========================================================
   // Bus master and checking
   // ==========================================================
   task automatic bus(input logic r, input logic [7:0] a,
                      input logic [31:0] dt, input logic [3:0] b);
      @(posedge clk);
      rd_req <= r;
      wr_req <= !r;
      addr   <= a;
      wdata  <= dt;
      be     <= b;
      do @(posedge clk); while (waitreq !== 1'b0);
      rd_req <= 1'b0;
      wr_req <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      bus(1'b0, a, {24'h0, v}, 4'hF);
   endtask

   // The expectation is queued before the request goes out
   task automatic rd(input logic [7:0] a, input logic [7:0] v);
      exp_q.push_back({24'h0, v});
      bus(1'b1, a, 32'h0, 4'hF);
   endtask

   task automatic cmp(input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   always @(posedge clk) begin
      if (rd_req && !waitreq && exp_q.size() > 0)
         cmp(exp_q.pop_front(), rdata);
   end

   // ==========================================================
   // Reference behaviour
   // ==========================================================
   task automatic model(input logic [2:0] op);
      case (op)
         3'h1: begin
            ea = {em[6:0], ef[0]};
            ef[0] = em[7];
            er = ea;
         end
         3'h2: begin
            em = {em[0], em[7:1]};
            er = em;
         end
         3'h3: begin
            ea = {em[0], em[7:1]};
            er = ea;
         end
         3'h4: begin
            er = {ef[0], em[7:1]};
            ef[0] = em[0];
            em = er;
         end
         3'h5: begin
            ea = {ef[0], em[7:1]};
            ef[0] = em[0];
            er = ea;
         end
         3'h6: begin
            // Carry in is an active-low borrow
            d = {1'b0, ea} - {1'b0, em} - {8'h00, !ef[0]};
            nb = {1'b0, ea[3:0]} - {1'b0, em[3:0]} - {4'h0, !ef[0]};
            ef[1] = !nb[4];
            ef[3] = (ea[7] != em[7]) && (d[7] != ea[7]);
            ef[0] = !d[8];
            ea = d[7:0];
            ef[2] = (ea == 8'h00);
            er = ea;
         end
         default: er = em;
      endcase
   endtask

   task automatic summarize;
      if (exp_q.size() != 0)
         mismatches++;
      $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         summarize();
      end
   end

   // ==========================================================
   // Scenarios
   // ==========================================================
   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      rd_req = 1'b0;
      wr_req = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      be = 4'h0;
      void'($urandom(61));
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      // Reset values, then two unmapped words
      for (int a = 0; a <= 24; a += 4)
         rd(8'(a), 8'h00);
      // Refused writes leave everything at zero
      bus(1'b0, rab_pkg::OFS_MEM, 32'h5A, 4'hE);
      wr(rab_pkg::OFS_RESULT, 8'hA5);
      wr(8'h20, 8'hA5);
      rd(rab_pkg::OFS_MEM, 8'h00);
      rd(rab_pkg::OFS_RESULT, 8'h00);
      rd(8'h20, 8'h00);
      // Every op code, random operands, some equal for a zero difference
      repeat (6) for (int op = 0; op < 8; op++) begin
         em = 8'($urandom);
         ea = 8'($urandom);
         ef = 4'($urandom);
         if ($urandom % 4 == 0)
            em = ea;
         wr(rab_pkg::OFS_MEM, em);
         wr(rab_pkg::OFS_ACC, ea);
         wr(rab_pkg::OFS_FLAGS, {4'h0, ef});
         wr(rab_pkg::OFS_CTRL, 8'(op));
         model(3'(op));
         rd(rab_pkg::OFS_MEM, em);
         rd(rab_pkg::OFS_ACC, ea);
         rd(rab_pkg::OFS_FLAGS, {4'h0, ef});
         rd(rab_pkg::OFS_RESULT, er);
         rd(rab_pkg::OFS_CTRL, {3'h0, op == 2 || op == 4,
            op == 1 || op == 3 || op == 5 || op == 6, 3'(op)});
      end
      // Enable low stalls a write until it returns high
      @(posedge clk);
      ce <= 1'b0;
      fork
         wr(rab_pkg::OFS_ACC, 8'h3C);
         begin
            repeat (3) @(posedge clk);
            ce <= 1'b1;
         end
      join
      rd(rab_pkg::OFS_ACC, 8'h3C);
      wr(rab_pkg::OFS_FLAGS, 8'h0F);
      // Second reset in mid-run clears the state
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rd(rab_pkg::OFS_ACC, 8'h00);
      rd(rab_pkg::OFS_FLAGS, 8'h00);
      repeat (4) @(posedge clk);
      summarize();
   end
endmodule
`default_nettype wire
